// [rtl/ata_pkg.sv]
// Constants, types and carriers for the ATA command execution block.
package ata_pkg;
  localparam logic [5:0]  ATA_OFF_DATA    = 6'h00;
  localparam logic [5:0]  ATA_OFF_ERRFEAT = 6'h04;
  localparam logic [5:0]  ATA_OFF_SC      = 6'h08;
  localparam logic [5:0]  ATA_OFF_SN      = 6'h0c;
  localparam logic [5:0]  ATA_OFF_CL      = 6'h10;
  localparam logic [5:0]  ATA_OFF_CH      = 6'h14;
  localparam logic [5:0]  ATA_OFF_DH      = 6'h18;
  localparam logic [5:0]  ATA_OFF_STATCMD = 6'h1c;
  localparam logic [5:0]  ATA_OFF_ALTSTAT = 6'h20;
  localparam logic [5:0]  ATA_OFF_GEOM    = 6'h24;
  localparam logic [7:0]  ATA_ERR_ABRT    = 8'h04;
  localparam logic [7:0]  ATA_ERR_IDNF    = 8'h10;
  localparam logic [7:0]  ATA_ERR_UNC     = 8'h40;
  localparam logic [7:0]  ATA_DIAG_OK     = 8'h01;
  localparam logic [7:0]  ATA_DIAG_FMT    = 8'h02;
  localparam logic [7:0]  ATA_DH_RESET    = 8'ha0;
  localparam logic [7:0]  ATA_SC_RESET    = 8'h01;
  localparam logic [7:0]  ATA_SN_RESET    = 8'h01;
  localparam int          ATA_DH_DRV_BIT  = 4;
  localparam int          ATA_DH_LBA_BIT  = 6;
  localparam int          ATA_SECT_BYTES  = 512;
  localparam int          ATA_ECC_BYTES   = 4;
  localparam int          ATA_CLK_NS      = 8;
  localparam int          ATA_STBY_NS     = 2000;
  localparam int          ATA_STBY_CYC    = (ATA_STBY_NS + ATA_CLK_NS - 1) / ATA_CLK_NS;

  typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_MED_START, ST_MED_WAIT,
                            ST_XFER_OUT, ST_XFER_IN, ST_ECC} ata_st_t;
  typedef enum logic [2:0] {OP_NONE, OP_READ, OP_WRITE, OP_VERIFY, OP_FORMAT, OP_DIAG} ata_op_t;
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_IDLE, PWR_STANDBY} ata_pwr_t;

  typedef struct packed {
    logic        req;
    ata_op_t     op;
    logic        lba_mode;
    logic [27:0] addr;
  } ata_med_req_t;

  typedef struct packed {
    logic       done;
    logic       err;
    logic       we;
    logic [9:0] baddr;
    logic [7:0] wdata;
  } ata_med_rsp_t;

  typedef struct packed {
    ata_st_t      st;
    ata_op_t      op;
    logic         bsy;
    logic         drdy;
    logic         dsc;
    logic         drq;
    logic         err;
    logic         intrq;
    logic         stop;
    logic         long_x;
    logic [7:0]   err_reg;
    logic [7:0]   feat;
    logic [7:0]   sc;
    logic [7:0]   sn;
    logic [7:0]   cl;
    logic [7:0]   ch;
    logic [7:0]   dh;
    logic [7:0]   cmd;
    logic [7:0]   spt;
    logic [3:0]   hmax;
    logic [8:0]   cnt;
    logic [9:0]   ptr;
    logic [31:0]  ecc;
    ata_pwr_t     pwr;
    logic         stby_pend;
    logic [15:0]  stby_tmr;
    logic         a_valid;
    logic         a_write;
    logic [5:0]   a_addr;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic         hresp;
    ata_med_req_t med;
    logic [7:0]   med_rdata;
  } ata_state_t;
endpackage : ata_pkg

// [rtl/ata_cmd_exec.sv]
// Task-file registers and command sequencer of a flash ATA drive behind an AHB-Lite slave.
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ata_cmd_exec
  import ata_pkg::*;
#(
  parameter int STBY_CYC = ATA_STBY_CYC
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic         hready,
  input  wire logic [31:0]  hwdata,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  output logic              intrq,
  output ata_pwr_t          pwr_mode,
  output ata_med_req_t      med_req,
  input  wire ata_med_rsp_t med_rsp,
  output logic [7:0]        med_buf_rdata
);
  localparam int BUF_BYTES = ATA_SECT_BYTES + ATA_ECC_BYTES;
  localparam logic [9:0] LEN_SECT = 10'(ATA_SECT_BYTES);
  localparam logic [9:0] LEN_LONG = 10'(BUF_BYTES);

  ata_state_t q, n;
  logic [7:0] buf_mem [BUF_BYTES];
  logic       bw_en;
  logic [9:0] bw_addr;
  logic [7:0] bw_data;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [27:0] next_addr(input logic lba, input logic [27:0] a,
                                            input logic [7:0] spt, input logic [3:0] hmax);
    logic [7:0]  s;
    logic [15:0] c;
    logic [3:0]  h;
    s = a[7:0];
    c = a[23:8];
    h = a[27:24];
    if (lba) begin
      return 28'(a + 28'h0000001);
    end
    if (s >= spt) begin
      s = 8'h01;
      if (h >= hmax) begin
        h = 4'h0;
        c = 16'(c + 16'h0001);
      end else begin
        h = 4'(h + 4'h1);
      end
    end else begin
      s = 8'(s + 8'h01);
    end
    return {h, c, s};
  endfunction : next_addr

  function automatic ata_state_t finish(input ata_state_t s, input logic e, input logic [7:0] er);
    ata_state_t r;
    r = s;
    r.st      = ST_IDLE;
    r.bsy     = 1'b0;
    r.drq     = 1'b0;
    r.drdy    = 1'b1;
    r.err     = e;
    r.err_reg = er;
    r.intrq   = 1'b1;
    r.med.req = 1'b0;
    return r;
  endfunction : finish

  ////////////////////////////////////////////////////////////////////////////
  logic [27:0] cur_addr;
  logic [27:0] nxt_addr;
  logic        lba;
  logic        geom_bad;
  logic        rd_data;
  logic        rd_stat;
  logic        wr_cmd;
  logic        last_byte;
  logic [9:0]  xfer_len;

  always_comb begin
    n         = q;
    bw_en     = 1'b0;
    bw_addr   = q.ptr;
    bw_data   = hwdata[7:0];
    lba       = q.dh[ATA_DH_LBA_BIT];
    cur_addr  = {q.dh[3:0], q.ch, q.cl, q.sn};
    nxt_addr  = next_addr(lba, cur_addr, q.spt, q.hmax);
    geom_bad  = !lba && (q.sn == 8'h00 || q.sn > q.spt || q.dh[3:0] > q.hmax);
    xfer_len  = q.long_x ? LEN_LONG : LEN_SECT;
    last_byte = (q.ptr == 10'(xfer_len - 10'd1));
    rd_data   = 1'b0;
    rd_stat   = 1'b0;
    wr_cmd    = 1'b0;
    n.med_rdata = buf_mem[med_rsp.baddr];

    // Address phase: capture it, build the read answer, run read side effects.
    n.a_valid = hsel && htrans[1] && hready;
    n.a_write = hwrite;
    n.a_addr  = haddr[7:2] << 2;
    n.hrdata  = 32'h0000_0000;
    if (n.a_valid && !hwrite) begin
      if (q.bsy && n.a_addr <= ATA_OFF_STATCMD) begin
        n.hrdata = {24'h0, q.bsy, q.drdy, 1'b0, q.dsc, q.drq, 2'b00, q.err};
      end else begin
        case (n.a_addr)
          ATA_OFF_DATA:    n.hrdata = {24'h0, buf_mem[q.ptr]};
          ATA_OFF_ERRFEAT: n.hrdata = {24'h0, q.err_reg};
          ATA_OFF_SC:      n.hrdata = {24'h0, q.sc};
          ATA_OFF_SN:      n.hrdata = {24'h0, q.sn};
          ATA_OFF_CL:      n.hrdata = {24'h0, q.cl};
          ATA_OFF_CH:      n.hrdata = {24'h0, q.ch};
          ATA_OFF_DH:      n.hrdata = {24'h0, q.dh};
          ATA_OFF_STATCMD,
          ATA_OFF_ALTSTAT: n.hrdata = {24'h0, q.bsy, q.drdy, 1'b0, q.dsc, q.drq, 2'b00, q.err};
          ATA_OFF_GEOM:    n.hrdata = {20'h0, q.hmax, q.spt};
          default:         n.hrdata = 32'h0000_0000;
        endcase
      end
      rd_data = (n.a_addr == ATA_OFF_DATA) && q.drq && (q.st == ST_XFER_OUT);
      rd_stat = (n.a_addr == ATA_OFF_STATCMD);
    end
    if (rd_stat) begin
      n.intrq = 1'b0;
    end

    // Data phase of a write: plain task-file registers only while BSY is clear.
    if (q.a_valid && q.a_write && !q.bsy) begin
      case (q.a_addr)
        ATA_OFF_ERRFEAT: n.feat = hwdata[7:0];
        ATA_OFF_SC:      n.sc   = hwdata[7:0];
        ATA_OFF_SN:      n.sn   = hwdata[7:0];
        ATA_OFF_CL:      n.cl   = hwdata[7:0];
        ATA_OFF_CH:      n.ch   = hwdata[7:0];
        ATA_OFF_DH:      n.dh   = hwdata[7:0];
        default:         ;
      endcase
    end
    wr_cmd = q.a_valid && q.a_write && (q.a_addr == ATA_OFF_STATCMD) && !q.dh[ATA_DH_DRV_BIT];

    // Power: the standby sequence runs after its interrupt has already been raised.
    if (q.stby_pend) begin
      if (q.stby_tmr == 16'h0000) begin
        n.stby_pend = 1'b0;
        n.pwr       = PWR_STANDBY;
      end else begin
        n.stby_tmr = 16'(q.stby_tmr - 16'h0001);
      end
    end

    case (q.st)
      ST_IDLE: ;
      ST_DECODE: begin
        n.cnt    = (q.sc == 8'h00) ? 9'd256 : {1'b0, q.sc};
        n.long_x = 1'b0;
        n.ptr    = 10'h000;
        n.ecc    = 32'h0000_0000;
        n.stop   = 1'b0;
        casez (q.cmd)
          8'h1?: n = finish(n, 1'b0, 8'h00);
          8'h7?: begin
            n     = finish(n, 1'b0, 8'h00);
            n.dsc = 1'b1;
          end
          8'h20, 8'h21, 8'h22, 8'h23: begin
            n.long_x = q.cmd[1];
            if (q.cmd[1]) begin
              n.cnt = 9'd1;
            end
            n.op = OP_READ;
            n.st = ST_MED_START;
          end
          8'h30, 8'h31, 8'h32, 8'h33: begin
            n.long_x = q.cmd[1];
            if (q.cmd[1]) begin
              n.cnt = 9'd1;
            end
            n.op  = OP_WRITE;
            n.drq = 1'b1;
            n.bsy = 1'b0;
            n.st  = ST_XFER_IN;
          end
          8'h40, 8'h41: begin
            n.op = OP_VERIFY;
            n.st = ST_MED_START;
          end
          8'h50: begin
            n.op  = OP_FORMAT;
            n.drq = 1'b1;
            n.bsy = 1'b0;
            n.st  = ST_XFER_IN;
          end
          8'h90: begin
            n.op = OP_DIAG;
            n.st = ST_MED_START;
          end
          8'h91: begin
            n.spt  = q.sc;
            n.hmax = q.dh[3:0];
            n      = finish(n, 1'b0, 8'h00);
          end
          8'h94, 8'he0, 8'h96, 8'he2: begin
            n = finish(n, 1'b0, 8'h00);
            if (q.pwr != PWR_STANDBY && !q.stby_pend) begin
              n.stby_pend = 1'b1;
              n.stby_tmr  = 16'(STBY_CYC);
            end
          end
          8'h95, 8'he1: begin
            n.pwr       = PWR_IDLE;
            n.stby_pend = 1'b0;
            n           = finish(n, 1'b0, 8'h00);
          end
          default: begin
            n     = finish(n, 1'b1, ATA_ERR_ABRT);
            n.sc  = q.sc;
          end
        endcase
      end
      ST_MED_START: begin
        if (q.op != OP_DIAG && q.op != OP_FORMAT && geom_bad) begin
          n    = finish(n, 1'b1, ATA_ERR_IDNF);
          n.sc = q.cnt[7:0];
        end else begin
          n.med.req      = 1'b1;
          n.med.op       = q.op;
          n.med.lba_mode = lba;
          n.med.addr     = cur_addr;
          n.st           = ST_MED_WAIT;
        end
      end
      ST_MED_WAIT: begin
        if (med_rsp.done) begin
          n.med.req = 1'b0;
          n.dsc     = 1'b1;
          case (q.op)
            OP_READ: begin
              n.drq   = 1'b1;
              n.bsy   = 1'b0;
              n.intrq = 1'b1;
              n.ptr   = 10'h000;
              n.st    = ST_XFER_OUT;
              if (med_rsp.err && !q.long_x) begin
                n.stop    = 1'b1;
                n.err     = 1'b1;
                n.err_reg = ATA_ERR_UNC;
              end
            end
            OP_WRITE, OP_VERIFY: begin
              if (med_rsp.err) begin
                n    = finish(n, 1'b1, ATA_ERR_UNC);
                n.sc = q.cnt[7:0];
              end else if (q.cnt == 9'd1) begin
                n    = finish(n, 1'b0, 8'h00);
                n.sc = 8'h00;
              end else begin
                n.cnt = 9'(q.cnt - 9'd1);
                {n.dh[3:0], n.ch, n.cl, n.sn} = nxt_addr;
                n.ptr = 10'h000;
                n.ecc = 32'h0000_0000;
                if (q.op == OP_WRITE) begin
                  n.drq = 1'b1;
                  n.bsy = 1'b0;
                  n.st  = ST_XFER_IN;
                end else begin
                  n.st = ST_MED_START;
                end
              end
            end
            OP_FORMAT: n = finish(n, 1'b0, 8'h00);
            OP_DIAG:   n = finish(n, 1'b0, med_rsp.err ? ATA_DIAG_FMT : ATA_DIAG_OK);
            default:   n = finish(n, 1'b1, ATA_ERR_ABRT);
          endcase
        end
      end
      ST_XFER_OUT: begin
        if (rd_data) begin
          n.ptr = 10'(q.ptr + 10'd1);
          if (last_byte) begin
            n.drq = 1'b0;
            n.bsy = 1'b1;
            if (q.stop) begin
              n    = finish(n, 1'b1, ATA_ERR_UNC);
              n.sc = q.cnt[7:0];
            end else if (q.cnt == 9'd1) begin
              n    = finish(n, 1'b0, 8'h00);
              n.sc = 8'h00;
            end else begin
              n.cnt = 9'(q.cnt - 9'd1);
              {n.dh[3:0], n.ch, n.cl, n.sn} = nxt_addr;
              n.st  = ST_MED_START;
            end
          end
        end
      end
      ST_XFER_IN: begin
        if (q.a_valid && q.a_write && q.a_addr == ATA_OFF_DATA) begin
          bw_en = (q.op != OP_FORMAT);
          n.ptr = 10'(q.ptr + 10'd1);
          n.ecc[8*q.ptr[1:0] +: 8] = q.ecc[8*q.ptr[1:0] +: 8] ^ hwdata[7:0];
          if (last_byte) begin
            n.drq = 1'b0;
            n.bsy = 1'b1;
            n.st  = (q.op == OP_WRITE && !q.long_x) ? ST_ECC : ST_MED_START;
          end
        end
      end
      ST_ECC: begin
        bw_en   = 1'b1;
        bw_data = q.ecc[8*q.ptr[1:0] +: 8];
        n.ptr   = 10'(q.ptr + 10'd1);
        if (q.ptr == 10'(LEN_LONG - 10'd1)) begin
          n.st = ST_MED_START;
        end
      end
      default: n.st = ST_IDLE;
    endcase

    if (wr_cmd) begin
      n.cmd       = hwdata[7:0];
      n.st        = ST_DECODE;
      n.bsy       = 1'b1;
      n.drq       = 1'b0;
      n.err       = 1'b0;
      n.err_reg   = 8'h00;
      n.med.req   = 1'b0;
      n.intrq     = 1'b0;
      // A standby command must not wake a drive that already stands in standby.
      if (q.pwr == PWR_STANDBY && !(hwdata[7:0] inside {8'h94, 8'he0, 8'h96, 8'he2})) begin
        n.pwr = PWR_ACTIVE;
      end
    end
    n.hreadyout = 1'b1;
    n.hresp     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q           <= '0;
      q.st        <= ST_IDLE;
      q.drdy      <= 1'b1;
      q.sc        <= ATA_SC_RESET;
      q.sn        <= ATA_SN_RESET;
      q.dh        <= ATA_DH_RESET;
      q.pwr       <= PWR_ACTIVE;
      q.hreadyout <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // A media write and a host write never overlap: the host only writes while DRQ stands.
  always_ff @(posedge hclk) begin
    if (med_rsp.we) begin
      buf_mem[med_rsp.baddr] <= med_rsp.wdata;
    end else if (bw_en) begin
      buf_mem[bw_addr] <= bw_data;
    end
  end

  assign hrdata        = q.hrdata;
  assign hreadyout     = q.hreadyout;
  assign hresp         = q.hresp;
  assign intrq         = q.intrq;
  assign pwr_mode      = q.pwr;
  assign med_req       = q.med;
  assign med_buf_rdata = q.med_rdata;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_decode(logic [7:0] c);
    q.st == ST_DECODE && q.cmd == c;
  endsequence

  property p_abort;
    @(posedge hclk) disable iff (!hresetn) wr_cmd |=> q.st == ST_DECODE && q.bsy && !q.drq;
  endproperty
  a_abort: assert property (p_abort) else $error("command write did not restart sequencer");

  property p_recal;
    @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_DECODE && q.cmd[7:4] == 4'h1 && !wr_cmd) |=> !q.bsy && q.intrq && !q.err && !q.med.req;
  endproperty
  a_recal: assert property (p_recal) else $error("recalibrate did not complete at once");

  property p_seek;
    @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_DECODE && q.cmd[7:4] == 4'h7 && !wr_cmd) |=> q.dsc && !q.bsy && !q.err;
  endproperty
  a_seek: assert property (p_seek) else $error("seek did not report seek complete");

  property p_count_zero;
    @(posedge hclk) disable iff (!hresetn)
      (s_decode(8'h20) and (q.sc == 8'h00) and !wr_cmd) |=> q.cnt == 9'd256 && q.st == ST_MED_START;
  endproperty
  a_count_zero: assert property (p_count_zero) else $error("count zero not taken as 256");

  property p_read_drq;
    @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_MED_WAIT && q.op == OP_READ && med_rsp.done && !wr_cmd) |=> q.drq && !q.bsy ##1 q.drq || q.st != ST_XFER_OUT;
  endproperty
  a_read_drq: assert property (p_read_drq) else $error("no DRQ before read sector transfer");

  property p_verify_nodrq;
    @(posedge hclk) disable iff (!hresetn) (q.op == OP_VERIFY && q.st != ST_IDLE && q.st != ST_DECODE) |-> !q.drq;
  endproperty
  a_verify_nodrq: assert property (p_verify_nodrq) else $error("DRQ during verify");

  property p_diag;
    @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_MED_WAIT && q.op == OP_DIAG && med_rsp.done && !wr_cmd)
        |=> !q.bsy && q.intrq && q.err_reg == (med_rsp.err ? 8'h02 : 8'h01);
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic code wrong");

  property p_init_geom;
    @(posedge hclk) disable iff (!hresetn)
      (s_decode(8'h91) and !wr_cmd) |=> q.spt == $past(q.sc) && q.hmax == $past(q.dh[3:0]) && !q.bsy && !q.err;
  endproperty
  a_init_geom: assert property (p_init_geom) else $error("geometry not stored");

  property p_stat_ack;
    @(posedge hclk) disable iff (!hresetn)
      (rd_stat && q.st == ST_IDLE && !wr_cmd) |=> !q.intrq;
  endproperty
  a_stat_ack: assert property (p_stat_ack) else $error("status read left interrupt pending");

  property p_abort_flag;
    @(posedge hclk) disable iff (!hresetn)
      (s_decode(8'hc8) and !wr_cmd) |=> q.err && q.err_reg[2] && !q.bsy;
  endproperty
  a_abort_flag: assert property (p_abort_flag) else $error("invalid command not aborted");

  property p_stby_irq_first;
    @(posedge hclk) disable iff (!hresetn)
      (s_decode(8'h94) and (q.pwr != PWR_STANDBY) and !q.stby_pend and !wr_cmd) |=> q.intrq && q.pwr != PWR_STANDBY;
  endproperty
  a_stby_irq_first: assert property (p_stby_irq_first) else $error("standby before interrupt");

  property p_stby_skip;
    @(posedge hclk) disable iff (!hresetn)
      (q.st == ST_DECODE && q.cmd inside {8'h94, 8'he0, 8'h96, 8'he2} && q.pwr == PWR_STANDBY && !wr_cmd)
        |=> q.pwr == PWR_STANDBY && !q.stby_pend;
  endproperty
  a_stby_skip: assert property (p_stby_skip) else $error("standby sequence repeated");
endmodule : ata_cmd_exec
`default_nettype wire

// [verif/ata_media_model.sv]
// Same-clock media model answering the command block's media requests.
`timescale 1ns/1ps
`default_nettype none
module ata_media_model
  import ata_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire ata_med_req_t med_req,
  input  wire logic         fail,
  output ata_med_rsp_t      med_rsp
);
  logic [9:0] n_q;
  logic       run_q;
  logic       arm_q;
  // After a finished job the next starts only after req has dropped once, so a late-falling req never starts a phantom job.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_q     <= 10'h0;
      run_q   <= 1'b0;
      arm_q   <= 1'b1;
      med_rsp <= '0;
    end else begin
      med_rsp.done  <= 1'b0;
      med_rsp.we    <= 1'b0;
      med_rsp.wdata <= ~med_rsp.wdata;
      if (!med_req.req) begin
        run_q <= 1'b0;
        arm_q <= 1'b1;
      end else if (arm_q && !run_q) begin
        run_q <= 1'b1;
        n_q   <= 10'h0;
      end else if (run_q) begin
        n_q <= n_q + 10'h1;
        if ((med_req.op == OP_READ) && (n_q < 10'h200)) begin
          med_rsp.we    <= 1'b1;
          med_rsp.baddr <= n_q;
          med_rsp.wdata <= n_q[7:0] ^ 8'h5a;
        end else if ((n_q >= 10'h200) || ((med_req.op != OP_READ) && (n_q == 10'h3))) begin
          med_rsp.done <= 1'b1;
          med_rsp.err  <= fail;
          run_q        <= 1'b0;
          arm_q        <= 1'b0;
        end
      end
    end
  end
endmodule : ata_media_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the ATA command block with a media model behind it.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ata_pkg::*;
;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = 32'h0;
  logic         fail = 1'b0;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         intrq;
  logic         hresp;
  logic [7:0]   med_buf_rdata;
  ata_pwr_t     pwr_mode;
  ata_med_req_t med_req;
  ata_med_rsp_t med_rsp;
  logic [31:0]  r;
  int           errors = 0;
  int           checks = 0;

  initial forever #4 hclk = ~hclk;

  ata_cmd_exec #(.STBY_CYC(4)) ata_cmd_exec_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .intrq(intrq), .pwr_mode(pwr_mode), .med_req(med_req),
    .med_rsp(med_rsp), .med_buf_rdata(med_buf_rdata));
  ata_media_model ata_media_model_inst (.hclk(hclk), .hresetn(hresetn), .med_req(med_req), .fail(fail),
    .med_rsp(med_rsp));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic hw_wait();
    int k;
    for (k = 0; k < 50; k++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (k == 50) begin
      errors++;
      print_verdict();
    end
  endtask : hw_wait

  task automatic ahb(input logic w, input logic [5:0] a, input logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {26'h0, a};
    hw_wait();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    hw_wait();
    r = hrdata;
  endtask : ahb

  task automatic rdm(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 8'h0);
    cmp(r & m, e);
  endtask : rdm

  // A read right after a command write still sees the decode cycle with BSY set, so let decode finish first.
  task automatic cmd(input logic [7:0] c);
    ahb(1'b1, ATA_OFF_STATCMD, c);
    repeat (2) @(posedge hclk);
  endtask : cmd

  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    int k;
    for (k = 0; k < 2000; k++) begin
      ahb(1'b0, ATA_OFF_ALTSTAT, 8'h0);
      if ((r[7:0] & m) === v) break;
    end
    if (k == 2000) begin
      errors++;
      print_verdict();
    end
  endtask : poll

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_quick();
    logic [7:0] c [4] = '{8'h10, 8'h1f, 8'h70, 8'h7f};
    foreach (c[i]) begin
      cmd(c[i]);
      poll(8'h80, 8'h00);
      cmp({31'h0, intrq}, 32'h1);
      rdm(ATA_OFF_STATCMD, c[i][6] ? 32'h91 : 32'h81, c[i][6] ? 32'h10 : 32'h00);
      @(posedge hclk);
      cmp({31'h0, intrq}, 32'h0);
    end
    cmd(8'hc8);
    poll(8'h80, 8'h00);
    rdm(ATA_OFF_ERRFEAT, 32'hff, 32'h04);
    rdm(ATA_OFF_ALTSTAT, 32'h01, 32'h01);
  endtask : t_quick

  task automatic t_setup();
    ahb(1'b1, ATA_OFF_SC, 8'h11);
    ahb(1'b1, ATA_OFF_DH, 8'ha3);
    cmd(8'h91);
    poll(8'h80, 8'h00);
    rdm(ATA_OFF_GEOM, 32'hfff, 32'h311);
    ahb(1'b1, ATA_OFF_DH, 8'ha5);
    for (int f = 1; f >= 0; f--) begin
      fail <= f[0];
      cmd(8'h90);
      poll(8'h80, 8'h00);
      rdm(ATA_OFF_ERRFEAT, 32'hff, f ? 32'h02 : 32'h01);
    end
    ahb(1'b1, ATA_OFF_DH, 8'ha0);
    ahb(1'b1, ATA_OFF_SN, 8'h12);
    cmd(8'h40);
    poll(8'h80, 8'h00);
    rdm(ATA_OFF_ERRFEAT, 32'hff, 32'h10);
  endtask : t_setup

  task automatic t_media();
    ahb(1'b1, ATA_OFF_SC, 8'h01);
    ahb(1'b1, ATA_OFF_SN, 8'h02);
    cmd(8'h20);
    poll(8'h88, 8'h08);
    cmp({31'h0, intrq}, 32'h1);
    for (int i = 0; i < 512; i++) rdm(ATA_OFF_DATA, 32'hff, i[7:0] ^ 8'h5a);
    poll(8'h88, 8'h00);
    rdm(ATA_OFF_SC, 32'hff, 32'h00);
    rdm(ATA_OFF_SN, 32'hff, 32'h02);
    ahb(1'b1, ATA_OFF_SC, 8'h02);
    ahb(1'b1, ATA_OFF_SN, 8'h01);
    fail <= 1'b1;
    cmd(8'h20);
    poll(8'h88, 8'h08);
    rdm(ATA_OFF_ALTSTAT, 32'h01, 32'h01);
    for (int i = 0; i < 512; i++) rdm(ATA_OFF_DATA, 32'hff, i[7:0] ^ 8'h5a);
    poll(8'h80, 8'h00);
    rdm(ATA_OFF_ALTSTAT, 32'h09, 32'h01);
    rdm(ATA_OFF_SC, 32'hff, 32'h02);
    rdm(ATA_OFF_SN, 32'hff, 32'h01);
    cmp({24'h0, med_buf_rdata}, 32'ha5);
    cmd(8'h40);
    poll(8'h80, 8'h00);
    fail <= 1'b0;
    rdm(ATA_OFF_ALTSTAT, 32'h09, 32'h01);
    rdm(ATA_OFF_SC, 32'hff, 32'h02);
    rdm(ATA_OFF_SN, 32'hff, 32'h01);
    // Count zero runs 256 sectors: from head 0 sector 1 with 17 sectors and 4 heads it ends at cyl 3, head 3, sector 1.
    ahb(1'b1, ATA_OFF_SC, 8'h00);
    cmd(8'h40);
    poll(8'h80, 8'h00);
    rdm(ATA_OFF_SC, 32'hff, 32'h00);
    rdm(ATA_OFF_CL, 32'hff, 32'h03);
    rdm(ATA_OFF_DH, 32'hff, 32'ha3);
    cmd(8'h20);
    cmd(8'h10);
    poll(8'h80, 8'h00);
    rdm(ATA_OFF_ALTSTAT, 32'h09, 32'h00);
    cmp({31'h0, med_req.req}, 32'h0);
  endtask : t_media

  task automatic t_write();
    logic [7:0] c [4] = '{8'h30, 8'h32, 8'h50, 8'h30};
    ahb(1'b1, ATA_OFF_SN, 8'h01);
    foreach (c[i]) begin
      ahb(1'b1, ATA_OFF_SC, (i == 3) ? 8'h02 : 8'h01);
      fail <= (i == 3);
      cmd(c[i]);
      rdm(ATA_OFF_ALTSTAT, 32'h88, 32'h08);
      for (int b = 0; b < 512; b++) ahb(1'b1, ATA_OFF_DATA, b[7:0]);
      rdm(ATA_OFF_ALTSTAT, 32'h88, c[i][1] ? 32'h08 : 32'h80);
      for (int b = 0; b < (c[i][1] ? 4 : 0); b++) ahb(1'b1, ATA_OFF_DATA, 8'h00);
      poll(8'h80, 8'h00);
      cmp({31'h0, intrq}, 32'h1);
      rdm(ATA_OFF_ALTSTAT, 32'h09, (i == 3) ? 32'h01 : 32'h00);
      if (i != 2) rdm(ATA_OFF_SC, 32'hff, (i == 3) ? 32'h02 : 32'h00);
      rdm(ATA_OFF_SN, 32'hff, 32'h01);
    end
    fail <= 1'b0;
  endtask : t_write

  task automatic t_power();
    logic [7:0] c [6] = '{8'h94, 8'he0, 8'h96, 8'he2, 8'h95, 8'he1};
    foreach (c[i]) begin
      cmd(c[i]);
      repeat (2) @(posedge hclk);
      cmp({31'h0, intrq}, 32'h1);
      cmp({30'h0, pwr_mode}, {30'h0, (i == 0) ? PWR_ACTIVE : (i < 4) ? PWR_STANDBY : PWR_IDLE});
      repeat (8) @(posedge hclk);
      cmp({30'h0, pwr_mode}, {30'h0, (i < 4) ? PWR_STANDBY : PWR_IDLE});
    end
  endtask : t_power

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdm(ATA_OFF_ALTSTAT, 32'hff, 32'h40);
    cmp({31'h0, hresp}, 32'h0);
    t_quick();
    t_setup();
    t_media();
    t_write();
    t_power();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
